// ### src/crs_ctrl.sv
/*
  crs_ctrl: startup and reset control for loading the device: power-on
  delay, request input, open-drain status and load-complete lines, pin
  states, serial capture on the configuration clock, real-time
  decompression and the word stream to configuration memory.
  assumes: rst_n_i is the power-on reset; pins arrive asynchronously;
  config_clock_i is made by the host and may stop at any time.
*/
// Functional notes
// - power-on reset holds status and done low
// - host-driven schemes: user pins high-z during POR
// - POR delay chosen by scheme_select
// - user pins high-z until load completes; driven during POR unless host-driven
// - weak pull-ups on after POR until done
// - request input low keeps device in reset
// - request high releases the status line
// - after status release, accept configuration data
// - decompress stream on the fly into memory
// - decompression never slower than delivery
// - decompression only in serial schemes
// - remote update internal: active serial, nor parallel
// - release load_complete after all data received
// - serial bit captured on configuration clock rise
// - stopped configuration clock holds load state
`timescale 1ns/1ps
module crs_ctrl
  import crs_pkg::*;
#(
  parameter int FRAME_LEN = FRAME_WORDS
) (
  // core clock and power-on reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // configuration link
  input wire logic config_clock_i,
  input wire logic serial_data_i,
  // control pins
  input wire logic config_request_n_i,
  input wire logic device_select_n_i,
  input wire logic [2:0] scheme_select_i,
  input wire logic compress_en_i,
  // open-drain status line
  input wire logic config_ready_n_i,
  output logic config_ready_n_o,
  output logic config_ready_n_oe_o,
  // open-drain load-complete line
  input wire logic load_complete_i,
  output logic load_complete_o,
  output logic load_complete_oe_o,
  // pin state controls
  output logic user_io_hiz_o,
  output logic weak_pullup_en_o,
  output logic config_bus_hiz_o,
  output logic decomp_avail_o,
  output logic remote_update_int_o,
  output logic config_error_o,
  // configuration memory write stream
  output logic cfg_wr_valid_o,
  output logic [WORD_W-1:0] cfg_wr_data_o,
  input wire logic cfg_wr_ready_i
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  crs_pins_type pin_s1_ff, pin_s2_ff;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
    end else begin
      pin_s1_ff <= {config_request_n_i, config_ready_n_i, load_complete_i,
                    device_select_n_i, compress_en_i, scheme_select_i};
      pin_s2_ff <= pin_s1_ff;
    end
  end

  // ----------------------------------------------------------------
  // link domain: serial capture on the host's clock
  // ----------------------------------------------------------------
  logic en_l1_ff, en_l2_ff, link_en_ff, nxt_link_en, link_arst_n;
  logic [2:0] bit_cnt_ff, nxt_bit_cnt;
  logic [WORD_W-2:0] shift_ff, nxt_shift;
  logic [WORD_W-1:0] byte_ff, nxt_byte;
  logic tog_ff, nxt_tog;

  // nothing here runs without edges, so a halted clock freezes the load
  always_comb begin
    nxt_bit_cnt = '0;
    nxt_shift = shift_ff;
    nxt_byte = byte_ff;
    nxt_tog = tog_ff;
    if (en_l2_ff) begin
      nxt_shift = {shift_ff[WORD_W-3:0], serial_data_i};
      nxt_bit_cnt = bit_cnt_ff + 3'h1;
      if (bit_cnt_ff == 3'h7) begin
        nxt_byte = {shift_ff, serial_data_i};
        nxt_tog = !tog_ff;
      end
    end
  end

  always_ff @(posedge config_clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bit_cnt_ff <= '0;
      shift_ff <= '0;
      byte_ff <= '0;
      tog_ff <= 1'b0;
    end else begin
      bit_cnt_ff <= nxt_bit_cnt;
      shift_ff <= nxt_shift;
      byte_ff <= nxt_byte;
      tog_ff <= nxt_tog;
    end
  end

  // the enable drops at once even with the link clock halted and rises
  // only after two link edges, so a stale enable never takes bits
  assign link_arst_n = rst_n_i && link_en_ff;

  always_ff @(posedge config_clock_i or negedge link_arst_n) begin
    if (!link_arst_n) begin
      en_l1_ff <= 1'b0;
      en_l2_ff <= 1'b0;
    end else begin
      en_l1_ff <= 1'b1;
      en_l2_ff <= en_l1_ff;
    end
  end

  // ----------------------------------------------------------------
  // byte crossing into the core domain
  // ----------------------------------------------------------------
  // a byte stays put for eight link edges, far longer than the sync
  logic tog_s1_ff, tog_s2_ff, tog_s3_ff, byte_stb;
  logic fifo_in_ready, fifo_out_valid, fifo_out_ready, fifo_flush;
  logic [WORD_W-1:0] fifo_out_data;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tog_s1_ff <= 1'b0;
      tog_s2_ff <= 1'b0;
      tog_s3_ff <= 1'b0;
    end else begin
      tog_s1_ff <= tog_ff;
      tog_s2_ff <= tog_s1_ff;
      tog_s3_ff <= tog_s2_ff;
    end
  end

  assign byte_stb = tog_s2_ff ^ tog_s3_ff;

  crs_state_type st_ff, nxt_st;

  crs_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .flush_i(fifo_flush),
    .in_valid_i(byte_stb && st_ff == ST_CONFIG),
    .in_ready_o(fifo_in_ready),
    .in_data_i(byte_ff),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_data)
  );

  // ----------------------------------------------------------------
  // decompressor and write stream
  // ----------------------------------------------------------------
  crs_word_type out_ff, nxt_out;
  logic [RUN_CNT_W-1:0] run_ff, nxt_run;
  logic [15:0] word_cnt_ff, nxt_word_cnt;
  logic [2:0] sel_ff, nxt_sel;
  logic comp_ff, nxt_comp;
  logic accept, last_word, out_free;

  // a run byte costs at most nine cycles, a literal one; a byte takes
  // eight link clocks to arrive, so the fifo never fills from our side
  always_comb begin
    accept = out_ff.valid && cfg_wr_ready_i;
    last_word = accept && word_cnt_ff == 16'(FRAME_LEN - 1);
    out_free = !out_ff.valid || cfg_wr_ready_i;
    nxt_out = out_ff;
    nxt_run = run_ff;
    fifo_out_ready = 1'b0;
    if (accept) begin
      nxt_out.valid = 1'b0;
    end
    if (st_ff == ST_CONFIG && out_free) begin
      if (run_ff != '0) begin
        nxt_out = '{valid: 1'b1, data: '0};
        nxt_run = run_ff - RUN_CNT_W'(1);
      end else if (fifo_out_valid) begin
        fifo_out_ready = 1'b1;
        if (comp_ff && fifo_out_data[RUN_FLAG_BIT]) begin
          nxt_run = RUN_CNT_W'(fifo_out_data[RUN_LEN_W-1:0]) +
                    RUN_CNT_W'(1);
        end else begin
          nxt_out = '{valid: 1'b1, data: fifo_out_data};
        end
      end
    end
    nxt_word_cnt = word_cnt_ff + 16'(accept);
    if (st_ff != ST_CONFIG) begin
      nxt_out = '0;
      nxt_run = '0;
      nxt_word_cnt = '0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_ff <= '0;
      run_ff <= '0;
      word_cnt_ff <= '0;
    end else begin
      out_ff <= nxt_out;
      run_ff <= nxt_run;
      word_cnt_ff <= nxt_word_cnt;
    end
  end

  // ----------------------------------------------------------------
  // startup state machine
  // ----------------------------------------------------------------
  logic [POR_CNT_W-1:0] por_cnt_ff, nxt_por_cnt;
  logic overflow;

  always_comb begin
    overflow = byte_stb && !fifo_in_ready && st_ff == ST_CONFIG;
    nxt_st = st_ff;
    nxt_por_cnt = por_cnt_ff;
    nxt_sel = sel_ff;
    nxt_comp = comp_ff;
    case (st_ff)
      ST_POR: begin
        nxt_sel = pin_s2_ff.sel; // straps follow the pins until POR ends
        nxt_por_cnt = por_cnt_ff + POR_CNT_W'(1);
        if (por_cnt_ff >= por_cycles(pin_s2_ff.sel)) begin
          nxt_st = ST_RESET;
        end
      end
      ST_RESET: begin
        nxt_comp = pin_s2_ff.comp_en && decomp_ok(sel_ff);
        if (pin_s2_ff.req_n) begin
          nxt_st = ST_CONFIG;
        end
      end
      ST_CONFIG: begin
        if (!pin_s2_ff.req_n) begin
          nxt_st = ST_RESET;
        end else if (overflow) begin
          nxt_st = ST_ERROR;
        end else if (last_word) begin
          nxt_st = ST_DONE;
        end
      end
      ST_DONE, ST_ERROR: begin
        if (!pin_s2_ff.req_n) begin
          nxt_st = ST_RESET;
        end
      end
      default: nxt_st = ST_POR;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= ST_POR;
      por_cnt_ff <= '0;
      sel_ff <= '0;
      comp_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      por_cnt_ff <= nxt_por_cnt;
      sel_ff <= nxt_sel;
      comp_ff <= nxt_comp;
    end
  end

  // ----------------------------------------------------------------
  // registered pin controls
  // ----------------------------------------------------------------
  logic rdy_oe_ff, nxt_rdy_oe, done_oe_ff, nxt_done_oe;
  logic hiz_ff, nxt_hiz, pull_ff, nxt_pull, bus_hiz_ff, nxt_bus_hiz;
  logic dec_ff, nxt_dec, rem_ff, nxt_rem, err_ff, nxt_err;

  always_comb begin
    nxt_rdy_oe = nxt_st == ST_POR || nxt_st == ST_RESET ||
                 nxt_st == ST_ERROR;
    nxt_done_oe = nxt_st != ST_DONE;
    nxt_hiz = (nxt_st == ST_POR) ? host_driven(nxt_sel)
                                 : nxt_st != ST_DONE;
    nxt_pull = nxt_st != ST_POR && nxt_st != ST_DONE;
    nxt_bus_hiz = pin_s2_ff.dev_sel_n && !pin_s2_ff.req_n &&
                  !host_driven(nxt_sel);
    nxt_dec = decomp_ok(nxt_sel);
    nxt_rem = remote_int(nxt_sel);
    nxt_err = nxt_st == ST_ERROR;
    // accept link data only once the status pin has really risen
    nxt_link_en = nxt_st == ST_CONFIG && pin_s2_ff.status_n &&
                  !pin_s2_ff.dev_sel_n && host_driven(nxt_sel) &&
                  nxt_sel != SEL_HOST_PAR;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdy_oe_ff <= 1'b1;
      done_oe_ff <= 1'b1;
      hiz_ff <= 1'b1;
      pull_ff <= 1'b0;
      bus_hiz_ff <= 1'b0;
      dec_ff <= 1'b0;
      rem_ff <= 1'b0;
      err_ff <= 1'b0;
      link_en_ff <= 1'b0;
    end else begin
      rdy_oe_ff <= nxt_rdy_oe;
      done_oe_ff <= nxt_done_oe;
      hiz_ff <= nxt_hiz;
      pull_ff <= nxt_pull;
      bus_hiz_ff <= nxt_bus_hiz;
      dec_ff <= nxt_dec;
      rem_ff <= nxt_rem;
      err_ff <= nxt_err;
      link_en_ff <= nxt_link_en;
    end
  end

  assign fifo_flush = st_ff != ST_CONFIG;
  assign config_ready_n_o = 1'b0;
  assign load_complete_o = 1'b0;
  assign config_ready_n_oe_o = rdy_oe_ff;
  assign load_complete_oe_o = done_oe_ff;
  assign user_io_hiz_o = hiz_ff;
  assign weak_pullup_en_o = pull_ff;
  assign config_bus_hiz_o = bus_hiz_ff;
  assign decomp_avail_o = dec_ff;
  assign remote_update_int_o = rem_ff;
  assign config_error_o = err_ff;
  assign cfg_wr_valid_o = out_ff.valid;
  assign cfg_wr_data_o = out_ff.data;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_por_lines_low: assert property (
    st_ff == ST_POR |-> config_ready_n_oe_o && load_complete_oe_o)
    else $error("status or done line released during POR");
  chk_por_pin_hiz: assert property (
    st_ff == ST_POR && host_driven(sel_ff) |-> user_io_hiz_o)
    else $error("user pins driven during POR");
  chk_por_length: assert property (
    $past(st_ff) == ST_POR && st_ff == ST_RESET
      |-> $past(por_cnt_ff) >= por_cycles($past(sel_ff)))
    else $error("POR ended early");
  chk_hiz_pullup: assert property (
    st_ff != ST_POR && st_ff != ST_DONE |-> user_io_hiz_o && weak_pullup_en_o)
    else $error("user pins left high-z state before done");
  chk_request_reset: assert property (
    st_ff != ST_POR && !pin_s2_ff.req_n |=> st_ff == ST_RESET)
    else $error("device left reset while request low");
  chk_status_release: assert property (
    st_ff == ST_RESET && pin_s2_ff.req_n |=> !config_ready_n_oe_o)
    else $error("status not released after request");
  chk_link_gate: assert property (
    link_en_ff |-> st_ff == ST_CONFIG && pin_s2_ff.status_n)
    else $error("link enabled outside configuration");
  chk_done_release: assert property (
    last_word && st_ff == ST_CONFIG && pin_s2_ff.req_n && !overflow
      |=> !load_complete_oe_o ##0 st_ff == ST_DONE)
    else $error("load_complete not released after last word");
  chk_run_pace: assert property (
    st_ff == ST_CONFIG && run_ff != '0 && out_free && pin_s2_ff.req_n
      |=> cfg_wr_valid_o && cfg_wr_data_o == '0)
    else $error("run word not produced at once");
  chk_decomp_scheme: assert property (
    run_ff != '0 |-> decomp_ok(sel_ff))
    else $error("decompression in a scheme without it");
  chk_remote_scheme: assert property (
    st_ff != ST_POR |-> remote_update_int_o == remote_int(sel_ff))
    else $error("remote update flag wrong for scheme");

  cov_load_done: cover property (st_ff == ST_CONFIG ##1 st_ff == ST_DONE);
  cov_abort: cover property (st_ff == ST_CONFIG ##1 st_ff == ST_RESET);
  cov_run: cover property (run_ff != '0 ##1 load_complete_i);

endmodule // crs_ctrl

// ### src/crs_pkg.sv
/*
  crs_pkg: constants, scheme codes, state and carrier types for the
  configuration reset and startup controller.
  assumes: core clock of 40 MHz; everything that uses it imports crs_pkg::*.
*/
package crs_pkg;

  // ----------------------------------------------------------------
  // widths, depths and timing
  // ----------------------------------------------------------------
  localparam int WORD_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int FRAME_WORDS = 64;
  localparam int CORE_CLK_MHZ = 40;
  localparam int POR_FAST_US = 50;
  localparam int POR_SLOW_US = 100;
  localparam int POR_CNT_W = 13;
  localparam logic [POR_CNT_W-1:0] POR_FAST_CYC =
    POR_CNT_W'(POR_FAST_US * CORE_CLK_MHZ);
  localparam logic [POR_CNT_W-1:0] POR_SLOW_CYC =
    POR_CNT_W'(POR_SLOW_US * CORE_CLK_MHZ);

  // ----------------------------------------------------------------
  // compressed stream format: flag bit set means a run of zero words
  // ----------------------------------------------------------------
  localparam int RUN_FLAG_BIT = 7;
  localparam int RUN_LEN_W = 3;
  localparam int RUN_CNT_W = 4;

  // ----------------------------------------------------------------
  // scheme_select codes
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_ACT_SER_FAST = 3'h0;
  localparam logic [2:0] SEL_ACT_SER_SLOW = 3'h1;
  localparam logic [2:0] SEL_NOR_PAR = 3'h2;
  localparam logic [2:0] SEL_HOST_SER_FAST = 3'h3;
  localparam logic [2:0] SEL_HOST_SER_SLOW = 3'h4;
  localparam logic [2:0] SEL_HOST_PAR = 3'h5;
  localparam logic [2:0] SEL_JTAG = 3'h7;

  typedef enum {ST_POR, ST_RESET, ST_CONFIG, ST_DONE, ST_ERROR}
    crs_state_type;

  typedef struct packed {
    logic valid;
    logic [WORD_W-1:0] data;
  } crs_word_type;

  typedef struct packed {
    logic req_n;
    logic status_n;
    logic done;
    logic dev_sel_n;
    logic comp_en;
    logic [2:0] sel;
  } crs_pins_type;

  function automatic logic [POR_CNT_W-1:0] por_cycles(input logic [2:0] s);
    por_cycles = (s == SEL_ACT_SER_SLOW || s == SEL_HOST_SER_SLOW)
               ? POR_SLOW_CYC : POR_FAST_CYC;
  endfunction

  function automatic logic host_driven(input logic [2:0] s);
    host_driven = (s == SEL_HOST_SER_FAST || s == SEL_HOST_SER_SLOW ||
                   s == SEL_HOST_PAR);
  endfunction

  function automatic logic decomp_ok(input logic [2:0] s);
    decomp_ok = (s == SEL_ACT_SER_FAST || s == SEL_ACT_SER_SLOW ||
                 s == SEL_HOST_SER_FAST || s == SEL_HOST_SER_SLOW);
  endfunction

  function automatic logic remote_int(input logic [2:0] s);
    remote_int = (s == SEL_ACT_SER_FAST || s == SEL_ACT_SER_SLOW ||
                  s == SEL_NOR_PAR);
  endfunction

endpackage

// ### src/crs_mem.sv
/*
  crs_mem: simple dual-port storage with a registered read port.
  assumes: one clock; read data appear one edge after rd_en_i.
*/
`timescale 1ns/1ps
module crs_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW = $clog2(DEPTH)
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // write port
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  // read port
  input wire logic rd_en_i,
  input wire logic [AW-1:0] rd_addr_i,
  output logic [WIDTH-1:0] rd_data_o
);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [WIDTH-1:0] rd_data_ff;

  // storage is data only, so it carries no reset
  always_ff @(posedge core_clk_i) begin
    if (wr_en_i) begin
      mem_ff[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_ff <= '0;
    end else if (rd_en_i) begin
      rd_data_ff <= mem_ff[rd_addr_i];
    end
  end

  assign rd_data_o = rd_data_ff;

endmodule // crs_mem

// ### src/crs_fifo.sv
/*
  crs_fifo: synchronous FIFO with valid/ready on both sides, storage in
  crs_mem and an output slot fed from its registered read port.
  assumes: one clock; flush_i empties it in one edge.
*/
`timescale 1ns/1ps
module crs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW = $clog2(DEPTH)
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic flush_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  logic [AW:0] wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr;
  logic out_valid_ff, nxt_out_valid;
  logic full, empty, do_wr, do_rd;

  // ----------------------------------------------------------------
  // pointers
  // ----------------------------------------------------------------
  always_comb begin
    full = (wr_ptr_ff - rd_ptr_ff) == (AW+1)'(DEPTH);
    empty = wr_ptr_ff == rd_ptr_ff;
    do_wr = in_valid_i && !full && !flush_i;
    // refill the output slot only when it is free or being taken
    do_rd = !empty && !flush_i && (!out_valid_ff || out_ready_i);
    nxt_wr_ptr = flush_i ? '0 : wr_ptr_ff + (AW+1)'(do_wr);
    nxt_rd_ptr = flush_i ? '0 : rd_ptr_ff + (AW+1)'(do_rd);
    nxt_out_valid = flush_i ? 1'b0
                  : (do_rd || (out_valid_ff && !out_ready_i));
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      out_valid_ff <= 1'b0;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      out_valid_ff <= nxt_out_valid;
    end
  end

  crs_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_mem (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .wr_en_i(do_wr),
    .wr_addr_i(wr_ptr_ff[AW-1:0]),
    .wr_data_i(in_data_i),
    .rd_en_i(do_rd),
    .rd_addr_i(rd_ptr_ff[AW-1:0]),
    .rd_data_o(out_data_o)
  );

  assign in_ready_o = !full;
  assign out_valid_o = out_valid_ff;

endmodule // crs_fifo

// ### verif/crs_host.sv
/*
  crs_host: host model for the serial link, makes the link clock and
  presents serial data.
  assumes: the bench calls its tasks; the clock is 64 ns in frames only.
*/
`timescale 1ns/1ps
module crs_host (
  // link pins
  output logic config_clock_o,
  output logic serial_data_o
);
  initial begin
    config_clock_o = 1'b0;
    serial_data_o = 1'b0;
  end

  // one link clock pulse with the data line held
  task automatic pulse();
    #32 config_clock_o = 1'b1;
    #32 config_clock_o = 1'b0;
  endtask

  // msb first; the clock stands still after the byte
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      serial_data_o = b[i];
      pulse();
    end
    serial_data_o = ~serial_data_o;
  endtask
endmodule // crs_host

// ### verif/config_reset_startup_control_tb.sv
/*
  config_reset_startup_control_tb: self-checking bench for crs_ctrl in
  the host-driven serial scheme, with a host model on the link.
  assumes: both open-drain lines have pull-ups; frame length is 4 words.
*/
`timescale 1ns/1ps
module config_reset_startup_control_tb;
  import crs_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic req_n = 1'b1, sel_n = 1'b0, comp = 1'b1, wr_ready = 1'b0;
  logic [2:0] sel = SEL_HOST_SER_FAST;
  logic config_clock, sdata, rdy_oe, done_oe, hiz, pu, bus_hiz, dav, rem, cerr;
  logic rdy_o, done_o;
  logic wr_valid;
  logic [WORD_W-1:0] wr_data;
  logic [7:0] got[$];
  int err_count = 0;
  int checked = 0;
  int cyc = 0;
  int n;

  always #12.5 core_clk_i = ~core_clk_i;

  crs_host host (.config_clock_o(config_clock), .serial_data_o(sdata));

  crs_ctrl #(.FRAME_LEN(4)) dut (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .config_clock_i(config_clock), .serial_data_i(sdata),
    .config_request_n_i(req_n), .device_select_n_i(sel_n),
    .scheme_select_i(sel), .compress_en_i(comp),
    .config_ready_n_i(~rdy_oe), .config_ready_n_o(rdy_o),
    .config_ready_n_oe_o(rdy_oe),
    .load_complete_i(~done_oe), .load_complete_o(done_o),
    .load_complete_oe_o(done_oe),
    .user_io_hiz_o(hiz), .weak_pullup_en_o(pu),
    .config_bus_hiz_o(bus_hiz), .decomp_avail_o(dav),
    .remote_update_int_o(rem), .config_error_o(cerr),
    .cfg_wr_valid_o(wr_valid), .cfg_wr_data_o(wr_data),
    .cfg_wr_ready_i(wr_ready)
  );

  // ----------------------------------------------------------------
  // write-stream monitor, stalling sink and hang guard
  // ----------------------------------------------------------------
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      stop_test();
    end
  end

  // taken at the falling edge, where valid and ready already stand for
  // the rising edge that follows
  always @(negedge core_clk_i) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1) got.push_back(wr_data);
  end

  // every other cycle stalled, so held words are exercised
  always @(posedge core_clk_i) #1 wr_ready <= ~wr_ready;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge core_clk_i);
    #1;
  endtask

  task automatic stop_test();
    if (err_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic por_phase();
    tick(100);
    check(rdy_oe, 1'b1);
    check(done_oe, 1'b1);
    check(hiz, 1'b1);
    check(rdy_o, 1'b0);
    check(done_o, 1'b0);
    for (n = 100; n < 3000 && rdy_oe !== 1'b0; n++) tick(1);
    check(n >= 1995 && n <= 2012, 1'b1);
    check(hiz, 1'b1);
    check(pu, 1'b1);
  endtask

  task automatic abort_and_retry();
    host.send_byte(8'h5a);
    tick(1);
    req_n = 1'b0;
    tick(6);
    check(rdy_oe, 1'b1);
    got.delete();
    host.send_byte(8'hff);
    tick(6);
    check(rdy_oe, 1'b1);
    check(got.size(), 8'h00);
    req_n = 1'b1;
    for (n = 0; n < 20 && rdy_oe !== 1'b0; n++) tick(1);
    check(rdy_oe, 1'b0);
  endtask

  task automatic load_frame();
    logic [7:0] exp [4];
    exp = '{8'h5a, 8'h00, 8'h00, 8'h3c};
    tick(10);
    host.pulse();
    host.pulse();
    host.send_byte(8'h5a);
    #1000;
    host.send_byte(8'h81);
    host.send_byte(8'h3c);
    for (n = 0; n < 200 && done_oe !== 1'b0; n++) tick(1);
    check(done_oe, 1'b0);
    check(hiz, 1'b0);
    check(cerr, 1'b0);
    check(got.size(), 8'h04);
    for (int i = 0; i < 4 && i < got.size(); i++) begin
      check(got[i], exp[i]);
    end
  endtask

  // reload with compression off: flagged bytes must pass as literals
  task automatic plain_frame();
    logic [7:0] exp [4];
    exp = '{8'h81, 8'h00, 8'hc3, 8'h7e};
    comp = 1'b0;
    req_n = 1'b0;
    tick(6);
    check(done_oe, 1'b1);
    got.delete();
    req_n = 1'b1;
    for (n = 0; n < 20 && rdy_oe !== 1'b0; n++) tick(1);
    check(rdy_oe, 1'b0);
    check(pu, 1'b1);
    tick(10);
    host.pulse();
    host.pulse();
    foreach (exp[i]) host.send_byte(exp[i]);
    for (n = 0; n < 200 && done_oe !== 1'b0; n++) tick(1);
    check(done_oe, 1'b0);
    check(got.size(), 8'h04);
    for (int i = 0; i < 4 && i < got.size(); i++) begin
      check(got[i], exp[i]);
    end
  endtask

  task automatic scheme_table();
    logic [7:0] dec_map = 8'h1b;
    logic [7:0] rem_map = 8'h07;
    logic [7:0] hiz_map = 8'h38;
    for (int s = 0; s < 8; s++) begin
      sel = 3'(s);
      // straps are only taken while POR runs, so each scheme gets one
      rst_n_i = 1'b0;
      tick(1);
      rst_n_i = 1'b1;
      tick(6);
      check(dav, dec_map[s]);
      check(rem, rem_map[s]);
      check(hiz, hiz_map[s]);
    end
    sel = SEL_ACT_SER_FAST;
    sel_n = 1'b1;
    req_n = 1'b0;
    tick(6);
    check(bus_hiz, 1'b1);
  endtask

  initial begin
    tick(10);
    rst_n_i = 1'b1;
    por_phase();
    abort_and_retry();
    load_frame();
    plain_frame();
    scheme_table();
    stop_test();
  end
endmodule // config_reset_startup_control_tb
